// ---- bench/mcs_far_model.sv ----
// mcs_far_model: memory, ports and status latch beside the sequencer.
// assumes the bench sets wait count and read byte before each request.
module mcs_far_model
  import mcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] db_o,
  input  wire logic       db_oe,
  input  wire logic       sync,
  input  wire logic       done,
  input  wire logic [1:0] waits,
  input  wire logic [7:0] rbyte,
  output logic      [7:0] db_i,
  output logic            rdy,
  output logic      [7:0] stat,
  output logic      [7:0] wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy;
  logic       sync_d;
  logic       rel;
  logic [7:0] pat;
  logic [3:0] cnt;
  // wire level: device drive, else memory byte, else a moving pattern
  assign db_i = db_oe ? db_o : (busy ? rbyte : pat);
  // ready low until whole wait periods have passed
  assign rdy = (waits == 2'h0) || rel;
  // status latch, read window and wait counting
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy   <= 1'b0;
      sync_d <= 1'b0;
      rel    <= 1'b0;
      pat    <= 8'h5a;
      cnt    <= 4'h0;
      stat   <= 8'h00;
      wr     <= 8'h00;
    end else begin
      sync_d <= sync;
      pat    <= {pat[6:0], ~pat[7]};
      if (sync) stat <= db_o;
      // answer reads once status is off
      // stack cycles select the same memory here
      if (sync_d && !sync) busy <= stat[ST_WRN];
      else if (done) busy <= 1'b0;
      if (db_oe && !sync) wr <= db_o;
      if (sync && !sync_d) cnt <= 4'(3 * waits);
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      if (done) rel <= 1'b0;
      else if (cnt == 4'h1) rel <= 1'b1;
    end
  end
endmodule // mcs_far_model

// ---- bench/mcs_sequencer_chk.sv ----
// mcs_sequencer_chk: port assertions of the machine-cycle sequencer.
// assumes it is bound into mcs_sequencer; one clock, async reset.
module mcs_sequencer_chk
  import mcs_pkg::*;
(
  input wire logic       I_CLK_SYS,
  input wire logic       I_RST,
  input wire logic [7:0] O_DB_O,
  input wire logic       O_DB_OE,
  input wire logic       O_SYNC,
  input wire logic       O_WAIT,
  input wire logic       O_HLDA,
  input wire logic       O_PC_INC,
  input wire logic       O_PC_CLR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_sync_len:
    assert property ($rose(O_SYNC) |-> (O_SYNC && O_DB_OE)[*3] ##1 !O_SYNC)
    else $error("status window wrong");
  chk_rd_float:
    assert property ($fell(O_SYNC) && $past(O_DB_O[ST_WRN]) |-> !O_DB_OE)
    else $error("read cycle keeps driving");
  chk_wr_hold:
    assert property ($fell(O_SYNC) && !$past(O_DB_O[ST_WRN]) |->
      O_DB_OE ##1 (O_DB_OE && $stable(O_DB_O))[*3]) else $error("write data lost");
  chk_fetch_bits:
    assert property (O_SYNC && O_DB_O[ST_FIRST] && !O_DB_O[ST_IACK] |-> O_DB_O == 8'ha2)
    else $error("fetch status wrong");
  chk_halt_bits:
    assert property (O_SYNC && O_DB_O[ST_HACK] && !O_DB_O[ST_IACK] |-> O_DB_O == 8'h8a)
    else $error("halt status wrong");
  chk_null_pc:
    assert property (O_SYNC && O_DB_O == 8'h02 |-> !O_PC_INC[*4])
    else $error("null cycle advanced counter");
  chk_wait_whole:
    assert property ($rose(O_WAIT) |-> O_WAIT[*3])
    else $error("wait shorter than a period");
  chk_hold_float:
    assert property (O_HLDA && $past(O_HLDA) |-> !O_DB_OE)
    else $error("bus driven in hold");
  chk_rst_clear:
    assert property ($fell(I_RST) |-> ##[1:8] O_PC_CLR)
    else $error("no clear after reset");
  chk_clr_fetch:
    assert property (O_PC_CLR |-> ##[1:3] (O_SYNC && O_DB_O == 8'ha2))
    else $error("first cycle not a fetch");
  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  cov_hold: cover property (O_HLDA);
  cov_ack: cover property (O_SYNC && O_DB_O == 8'h2b);
  cov_wait: cover property ($rose(O_WAIT));
endmodule // mcs_sequencer_chk

bind mcs_sequencer mcs_sequencer_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
  .O_DB_O(O_DB_O), .O_DB_OE(O_DB_OE), .O_SYNC(O_SYNC), .O_WAIT(O_WAIT),
  .O_HLDA(O_HLDA), .O_PC_INC(O_PC_INC), .O_PC_CLR(O_PC_CLR));

// ---- bench/mcs_sequencer_test.sv ----
// mcs_sequencer_test: self-checking bench of the cycle sequencer.
// assumes the far model answers reads; the core side is driven here.
module mcs_sequencer_test
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, hold, intr, ien, valid, sd;
  mcs_req_t   req;
  logic [1:0] waits;
  logic [7:0] rbyte;
  wire  [7:0] db_o, db_i, stat, wr, rd_data;
  wire        rdy, ready, err, oe, sync, wt, hlda, rd_v, inc, clr, done;
  int         fails, num_checks, cyc, nnull, ninta, nclr;
  mcs_cyc_t   kl[6] = '{CYC_MRD, CYC_MWR, CYC_SRD, CYC_SWR, CYC_IRD, CYC_OWR};
  logic [7:0] ops[3] = '{8'hcd, 8'hc6, 8'hff};
  int         nb[3] = '{2, 1, 0};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  mcs_sequencer dut (.I_CLK_SYS(clk), .I_RST(rst), .I_RDY(rdy), .I_HOLD(hold),
    .I_INT(intr), .I_IRQ_EN(ien), .I_DB_I(db_i), .I_REQ_VALID(valid), .I_REQ(req),
    .O_REQ_READY(ready), .O_REQ_ERR(err), .O_DB_O(db_o), .O_DB_OE(oe), .O_SYNC(sync),
    .O_WAIT(wt), .O_HLDA(hlda), .O_RD_DATA(rd_data), .O_RD_VALID(rd_v),
    .O_PC_INC(inc), .O_PC_CLR(clr), .O_CYC_DONE(done));
  mcs_far_model u_far (.clk(clk), .rst(rst), .db_o(db_o), .db_oe(oe), .sync(sync),
    .done(done), .waits(waits), .rbyte(rbyte), .db_i(db_i), .rdy(rdy), .stat(stat),
    .wr(wr));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // status byte each cycle kind should show
  function automatic logic [7:0] exp_st(input mcs_cyc_t k);
    case (k)
      CYC_FETCH: return 8'ha2;
      CYC_MRD:   return 8'h82;
      CYC_SRD:   return 8'h86;
      CYC_SWR:   return 8'h04;
      CYC_IRD:   return 8'h42;
      CYC_OWR:   return 8'h10;
      default:   return 8'h00;
    endcase
  endfunction
  // sync starts of null and ack status, clears, and the hang limit
  always @(negedge clk) begin
    sd <= sync;
    if (sync === 1'b1 && sd === 1'b0 && db_o === 8'h02) nnull++;
    if (sync === 1'b1 && sd === 1'b0 && db_o === 8'h2b) ninta++;
    if (clr === 1'b1) nclr++;
    cyc++;
    if (cyc > 20000) begin
      fails++;
      test_done;
    end
  end
  // issue one request and follow it to its end
  task automatic run(input mcs_cyc_t k, input logic [2:0] t, input logic bad);
    int n, s, l, te, pi;
    logic [7:0] wd;
    wd = 8'($urandom);
    s = 0;
    pi = 0;
    n = 0;
    @(posedge clk);
    req   <= '{k, t, wd};
    valid <= 1'b1;
    do @(negedge clk); while (ready !== 1'b1 && ++n < 90);
    @(posedge clk);
    valid <= 1'b0;
    n = 0;
    while (n < 90 && !(s != 0 && done === 1'b1) && err !== 1'b1) begin
      @(negedge clk);
      n++;
      if (sync === 1'b1 && s == 0) s = n;
      if (rd_v === 1'b1) check(rd_data === rbyte, "read byte");
      if (inc === 1'b1) pi++;
    end
    check((err === 1'b1) == bad, "refusal");
    if (!bad) begin
      te = (k == CYC_FETCH && t < 3'h4) ? 4 : int'(t);
      l  = n - s;
      check(waits == 0 ? l == 3 * te - 2 : l > 3 * te - 2 && (l + 2) % 3 == 0, "length");
      check(stat === exp_st(k), "status byte");
      check(pi == int'(k inside {CYC_FETCH, CYC_MRD}), "counter step");
      if (k inside {CYC_MWR, CYC_SWR, CYC_OWR}) check(wr === wd, "write byte");
    end
  endtask
  // fetch the halt opcode and settle into the halt wait
  task automatic halt(input logic en);
    @(posedge clk);
    ien   <= en;
    waits <= 2'h0;
    rbyte <= HALT_OPCODE;
    run(CYC_FETCH, 3'h4, 1'b0);
    repeat (30) @(negedge clk);
    check(wt === 1'b1 && stat === 8'h8a, "halt wait");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {fails, num_checks, cyc, nnull, ninta, nclr} = '0;
    {rst, hold, intr, ien, valid, req, waits, rbyte} = '0;
    rst = 1'b1;
    void'($urandom(32'hb463));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // random cycles; every sixth one would be a sixth machine cycle
    for (int i = 0; i < 36; i++) begin
      @(posedge clk);
      waits <= 2'($urandom_range(2));
      rbyte <= 8'($urandom_range(8'h75));
      run(i % 6 == 0 ? CYC_FETCH : kl[$urandom_range(5)], 3'(3 + $urandom_range(2)), i % 6 == 5);
    end
    // each kind after a fresh fetch, so the machine cycle count stays legal
    foreach (kl[j]) begin
      run(CYC_FETCH, 3'h4, 1'b0);
      run(kl[j], 3'h3, 1'b0);
    end
    halt(1'b0);
    @(posedge clk);
    hold <= 1'b1;
    repeat (20) @(negedge clk);
    check(hlda === 1'b1 && oe === 1'b0, "hold in halt");
    @(posedge clk);
    hold <= 1'b0;
    repeat (20) @(negedge clk);
    check(hlda === 1'b0 && wt === 1'b1, "back to halt wait");
    @(posedge clk);
    intr <= 1'b1;
    repeat (40) @(negedge clk);
    check(wt === 1'b1 && ninta == 0, "masked interrupt");
    @(posedge clk);
    rst   <= 1'b1;
    rbyte <= 8'h00;
    @(posedge clk);
    rst  <= 1'b0;
    intr <= 1'b0;
    repeat (20) @(negedge clk);
    check(nclr == 2, "clear after reset");
    for (int i = 0; i < 3; i++) begin
      halt(1'b1);
      @(posedge clk);
      nnull = 0;
      ninta = 0;
      rbyte <= ops[i];
      intr  <= 1'b1;
      repeat (80) @(negedge clk);
      check(ninta == 1 && nnull == nb[i], "ack and nulls");
      @(posedge clk);
      intr <= 1'b0;
    end
    test_done;
  end
endmodule // mcs_sequencer_test

// ---- logic/mcs_sequencer.sv ----
// mcs_sequencer: bus machine-cycle sequencer of an 8-bit processor.
// assumes ready, hold and interrupt arrive from pins (synchronised here)
// and the core issues one cycle request at a time on the same clock.
//
// Overview of operation
// RULE1: memory read is fetch timing, only read status
// RULE2: memory read never the first machine cycle
// RULE3: write-output status is low when writing
// RULE4: status driven T1, removed after T2 phase-two
// RULE5: read cycles float data bus after status
// RULE6: write data follows status, held through T3
// RULE7: write data released at next T1 phase-two
// RULE8: stack cycles add stack status bit
// RULE9: input/output cycles flagged by their status bits
// RULE10: halt ack shows only memory-read and halt bits
// RULE11: halt ack only after fetching halt opcode
// RULE12: reset ends halt, fetch from zero
// RULE13: hold in halt, then back to halt wait
// RULE14: enabled interrupt ends halt via acknowledge cycle
// RULE15: disabled interrupts at halt: only reset exits
// RULE16: multi-byte opcode after acknowledge adds null cycles
// RULE17: null cycle: read timing, no count, no read; the code still latches the bus and pulses O_RD_VALID at T3
// RULE18: null cycle status bits all inactive
// RULE19: waits whole periods between T2 and T3
// RULE20: ready sampled in T2 before phase-two fall
// RULE21: clock source never stretched; waits instead
// RULE22: memory select may gate on stack status
// RULE23: cycles last three to five periods
// RULE24: outside latches status while sync is high
// RULE25: first-fetch on bit five, memory-read bit seven
module mcs_sequencer
  import mcs_pkg::*;
(
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  input  wire logic       I_RDY,
  input  wire logic       I_HOLD,
  input  wire logic       I_INT,
  input  wire logic       I_IRQ_EN,
  input  wire logic [7:0] I_DB_I,
  input  wire logic       I_REQ_VALID,
  input  wire mcs_req_t   I_REQ,
  output logic            O_REQ_READY,
  output logic            O_REQ_ERR,
  output logic [7:0]      O_DB_O,
  output logic            O_DB_OE,
  output logic            O_SYNC,
  output logic            O_WAIT,
  output logic            O_HLDA,
  output logic [7:0]      O_RD_DATA,
  output logic            O_RD_VALID,
  output logic            O_PC_INC,
  output logic            O_PC_CLR,
  output logic            O_CYC_DONE
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    mcs_tst_t   tst;
    logic [1:0] ph;
    mcs_cyc_t   cyc;
    logic [2:0] tcnt;
    logic [2:0] mnum;
    logic [7:0] wdat;
    logic [7:0] db_o;
    logic       db_oe;
    logic       sync;
    logic       boot;       // first fetch after reset pending
    logic       halt_pend;  // halt opcode fetched
    logic       ien_h;      // interrupt enable seen at halt
    logic       from_halt;  // acknowledge taken out of halt
    logic [1:0] nulls;
    logic       hlda;
    logic [7:0] rdat;
    logic       rd_valid;
    logic       pc_inc;
    logic       pc_clr;
    logic       done;
    logic       err;
    logic       rdy1, rdy2;
    logic       hold1, hold2;
    logic       int1, int2;
  } mcs_st_t;

  mcs_st_t st_reg;
  mcs_st_t st_next;
  logic    end_t;
  logic    last_t;
  logic    cyc_end;
  logic    req_ok;

  // ----------------------------------------------------------------
  // decoding functions
  // ----------------------------------------------------------------
  // status byte for a cycle kind
  function automatic logic [7:0] status_of(mcs_cyc_t k, logic halted);
    logic [7:0] s;
    s = ST_NONE;
    // RULE3 write low
    s[ST_WRN] = !(k inside {CYC_MWR, CYC_SWR, CYC_OWR});
    // RULE25 fetch bits
    s[ST_FIRST] = (k == CYC_FETCH) || (k == CYC_IACK);
    // RULE1 read only
    s[ST_MREAD] = k inside {CYC_FETCH, CYC_MRD, CYC_SRD, CYC_HALT};
    // RULE8 stack flag
    s[ST_STACK] = k inside {CYC_SRD, CYC_SWR};
    // RULE9 port flags
    s[ST_IN] = (k == CYC_IRD);
    s[ST_OUT] = (k == CYC_OWR);
    // RULE10 halt bits
    s[ST_HACK] = (k == CYC_HALT) || ((k == CYC_IACK) && halted);
    s[ST_IACK] = (k == CYC_IACK);
    // RULE18 null quiet
    return s;
  endfunction

  // extra bytes that an opcode needs
  function automatic logic [1:0] extra_bytes(logic [7:0] op);
    logic [1:0] n;
    n = NULLS_NONE;
    if ((op & 8'hC7) == 8'hC2 || (op & 8'hC7) == 8'hC4 ||
        op == 8'hC3 || op == 8'hCD || (op & 8'hCF) == 8'h01 ||
        op == 8'h22 || op == 8'h2A || op == 8'h32 || op == 8'h3A) begin
      n = NULLS_TWO;
    end else if ((op & 8'hC7) == 8'h06 || (op & 8'hC7) == 8'hC6 ||
                 op == 8'hD3 || op == 8'hDB) begin
      n = NULLS_ONE;
    end
    return n;
  endfunction

  // clamp a length to three..five periods
  function automatic logic [2:0] clamp_t(logic [2:0] t);
    logic [2:0] r;
    r = t;
    if (t < TCNT_MIN) begin
      r = TCNT_MIN;
    end else if (t > TCNT_MAX) begin
      r = TCNT_MAX;
    end
    return r;
  endfunction

  // true for cycles whose data moves from the device
  function automatic logic is_write(mcs_cyc_t k);
    return k inside {CYC_MWR, CYC_SWR, CYC_OWR};
  endfunction

  // load a new cycle into the record at T1
  function automatic mcs_st_t begin_cyc(mcs_st_t c, mcs_cyc_t k,
                                        logic [2:0] t, logic [2:0] m);
    mcs_st_t r;
    r      = c;
    r.cyc  = k;
    r.tst  = TS_T1;
    r.tcnt = clamp_t(t);
    r.mnum = m;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // cycle boundary and request handshake
  // ----------------------------------------------------------------
  assign end_t  = (st_reg.ph == PH_P2F);
  // RULE23 three to five
  assign last_t = (st_reg.tst == TS_T3 && st_reg.tcnt == TCNT_MIN) ||
                  (st_reg.tst == TS_T4 && st_reg.tcnt == TCNT_FETCH) ||
                  (st_reg.tst == TS_T5);
  assign cyc_end = end_t && ((st_reg.tst == TS_IDLE) || last_t);
  // ack byte sets the null count at its last edge: no request taken there
  assign req_ok  = cyc_end && !st_reg.boot && !st_reg.halt_pend &&
                   (st_reg.nulls == NULLS_NONE) &&
                   ((st_reg.cyc != CYC_IACK) || (st_reg.tst == TS_IDLE));
  assign O_REQ_READY = req_ok;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.pc_inc   = 1'b0;
    st_next.pc_clr   = 1'b0;
    st_next.done     = 1'b0;
    st_next.err      = 1'b0;
    st_next.rdy1     = I_RDY;
    st_next.rdy2     = st_reg.rdy1;
    st_next.hold1    = I_HOLD;
    st_next.hold2    = st_reg.hold1;
    st_next.int1     = I_INT;
    st_next.int2     = st_reg.int1;
    st_next.ph       = end_t ? PH_P1 : 2'(st_reg.ph + PH_ONE);

    // bus actions at the second-phase leading edge
    if (st_reg.ph == PH_P2R) begin
      case (st_reg.tst)
        TS_T1: begin
          // RULE4 status out
          st_next.db_o  = status_of(st_reg.cyc, st_reg.from_halt);
          st_next.db_oe = 1'b1;
          st_next.sync  = 1'b1;
        end
        TS_T2: begin
          st_next.sync = 1'b0;
          if (is_write(st_reg.cyc)) begin
            // RULE6 data after status
            st_next.db_o = st_reg.wdat;
          end else begin
            // RULE5 float for read
            st_next.db_oe = 1'b0;
          end
          // RULE17 no count in null
          st_next.pc_inc = (st_reg.cyc == CYC_FETCH) || (st_reg.cyc == CYC_MRD);
        end
        TS_IDLE, TS_HOLD: begin
          // RULE7 release after write
          st_next.db_oe = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // period transitions at the end of each clock period
    if (end_t) begin
      case (st_reg.tst)
        TS_T1: st_next.tst = TS_T2;
        TS_T2, TS_TW: begin
          // RULE11 halt waits here
          if (st_reg.cyc == CYC_HALT) begin
            st_next.tst = TS_HALT;
          // RULE20 ready sample
          end else if (!st_reg.rdy2) begin
            // RULE19 whole-period wait
            st_next.tst = TS_TW;
          end else begin
            st_next.tst = TS_T3;
          end
        end
        TS_T3: begin
          if (!is_write(st_reg.cyc)) begin
            st_next.rdat     = I_DB_I;
            st_next.rd_valid = 1'b1;
          end
          if (st_reg.cyc == CYC_FETCH && I_DB_I == HALT_OPCODE) begin
            // RULE15 remember enable
            st_next.halt_pend = 1'b1;
            st_next.ien_h     = I_IRQ_EN;
          end
          if (st_reg.cyc == CYC_IACK) begin
            // RULE16 null count
            st_next.nulls = extra_bytes(I_DB_I);
          end
          if (!last_t) begin
            st_next.tst = TS_T4;
          end
        end
        TS_T4: begin
          if (!last_t) begin
            st_next.tst = TS_T5;
          end
        end
        TS_HALT: begin
          // RULE14 interrupt ends halt
          if (st_reg.int2 && st_reg.ien_h) begin
            st_next           = begin_cyc(st_next, CYC_IACK, TCNT_MIN, MNUM_FIRST);
            st_next.from_halt = 1'b1;
            st_next.ien_h     = 1'b0;
          // RULE13 hold inside halt
          end else if (st_reg.hold2) begin
            st_next.tst  = TS_HOLD;
            st_next.hlda = 1'b1;
          end
        end
        TS_HOLD: begin
          // RULE13 back to halt
          if (!st_reg.hold2) begin
            st_next.tst  = TS_HALT;
            st_next.hlda = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // start of the following machine cycle
    if (cyc_end) begin
      st_next.done = (st_reg.tst != TS_IDLE);
      st_next.tst  = TS_IDLE;
      if (st_reg.boot) begin
        // RULE12 fetch from zero
        st_next        = begin_cyc(st_next, CYC_FETCH, TCNT_FETCH, MNUM_FIRST);
        st_next.boot   = 1'b0;
        st_next.pc_clr = 1'b1;
      end else if (st_reg.halt_pend) begin
        // RULE11 after halt opcode
        st_next           = begin_cyc(st_next, CYC_HALT, TCNT_MIN,
                                      3'(st_reg.mnum + MNUM_ONE));
        st_next.halt_pend = 1'b0;
      end else if (st_next.nulls != NULLS_NONE) begin
        // RULE16 null cycle
        st_next       = begin_cyc(st_next, CYC_NULL, TCNT_MIN,
                                  3'(st_reg.mnum + MNUM_ONE));
        st_next.nulls = 2'(st_next.nulls - NULLS_ONE);
      end else if (I_REQ_VALID && req_ok) begin
        st_next.from_halt = 1'b0;
        if (I_REQ.kind == CYC_FETCH) begin
          st_next = begin_cyc(st_next, CYC_FETCH,
                              (I_REQ.tcnt < TCNT_FETCH) ? TCNT_FETCH : I_REQ.tcnt,
                              MNUM_FIRST);
        // RULE2 no read as first
        end else if (I_REQ.kind inside {CYC_IACK, CYC_HALT, CYC_NULL} ||
                     st_reg.mnum >= MNUM_MAX) begin
          st_next.err = 1'b1;
        end else begin
          st_next      = begin_cyc(st_next, I_REQ.kind, I_REQ.tcnt,
                                   3'(st_reg.mnum + MNUM_ONE));
          st_next.wdat = I_REQ.wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      st_reg      <= '0;
      st_reg.tst  <= TS_IDLE;
      st_reg.cyc  <= CYC_FETCH;
      st_reg.ph   <= PH_P1;
      st_reg.tcnt <= TCNT_FETCH;
      st_reg.boot <= 1'b1;
      st_reg.rdy1 <= 1'b1;
      st_reg.rdy2 <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_DB_O     = st_reg.db_o;
  assign O_DB_OE    = st_reg.db_oe;
  assign O_SYNC     = st_reg.sync;
  assign O_WAIT     = (st_reg.tst == TS_TW) || (st_reg.tst == TS_HALT);
  assign O_HLDA     = st_reg.hlda;
  assign O_RD_DATA  = st_reg.rdat;
  assign O_RD_VALID = st_reg.rd_valid;
  assign O_PC_INC   = st_reg.pc_inc;
  assign O_PC_CLR   = st_reg.pc_clr;
  assign O_CYC_DONE = st_reg.done;
  assign O_REQ_ERR  = st_reg.err;

endmodule // mcs_sequencer

// ---- shared/mcs_pkg.sv ----
// mcs_pkg: constants, cycle kinds and carriers of the machine-cycle sequencer.
// assumes one system clock; clock periods and phases are made from it.
package mcs_pkg;

  // ----------------------------------------------------------------
  // sub-phases of one processor clock period
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_P1  = 2'h0;  // first-phase interval
  localparam logic [1:0] PH_P2R = 2'h1;  // second-phase leading edge
  localparam logic [1:0] PH_P2F = 2'h2;  // just before second-phase fall
  localparam logic [1:0] PH_ONE = 2'h1;

  // ----------------------------------------------------------------
  // status byte bit positions on the data bus
  // ----------------------------------------------------------------
  localparam int ST_IACK  = 0;
  localparam int ST_WRN   = 1;
  localparam int ST_STACK = 2;
  localparam int ST_HACK  = 3;
  localparam int ST_OUT   = 4;
  localparam int ST_FIRST = 5;
  localparam int ST_IN    = 6;
  localparam int ST_MREAD = 7;
  localparam logic [7:0] ST_NONE = 8'h00;

  // ----------------------------------------------------------------
  // cycle lengths, opcodes and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] TCNT_MIN   = 3'h3;
  localparam logic [2:0] TCNT_FETCH = 3'h4;
  localparam logic [2:0] TCNT_MAX   = 3'h5;
  localparam logic [2:0] MNUM_FIRST = 3'h1;
  localparam logic [2:0] MNUM_MAX   = 3'h5;
  localparam logic [2:0] MNUM_ONE   = 3'h1;
  localparam logic [7:0] HALT_OPCODE = 8'h76;
  localparam logic [1:0] NULLS_NONE = 2'h0;
  localparam logic [1:0] NULLS_ONE  = 2'h1;
  localparam logic [1:0] NULLS_TWO  = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CYC_FETCH, CYC_MRD, CYC_MWR, CYC_SRD, CYC_SWR,
    CYC_IRD, CYC_OWR, CYC_IACK, CYC_HALT, CYC_NULL
  } mcs_cyc_t;

  typedef enum logic [3:0] {
    TS_IDLE, TS_T1, TS_T2, TS_TW, TS_T3, TS_T4, TS_T5, TS_HALT, TS_HOLD
  } mcs_tst_t;

  typedef struct packed {
    mcs_cyc_t   kind;   // requested cycle kind
    logic [2:0] tcnt;   // clock periods wanted, 3 to 5
    logic [7:0] wdata;  // byte for write cycles
  } mcs_req_t;

endpackage : mcs_pkg
